// *** shared/sdp_pkg.sv ***
// ----------------------------------------------------------------------------
// divider programming port: shared constants and types
// ----------------------------------------------------------------------------
package sdp_pkg;

    // ------------------------------------------------------------------------
    // register widths
    // ------------------------------------------------------------------------
    localparam int PRIM_WIDTH = 20;             // primary and secondary words
    localparam int ENH_WIDTH  = 8;              // enhancement options
    localparam int BUS_WIDTH  = 8;              // parallel data bus

    // ------------------------------------------------------------------------
    // primary word layout, most significant bit shifted first
    // ------------------------------------------------------------------------
    localparam int UPPER_LSB  = 16;             // upper nibble: ref[5:4], main[8:7]
    localparam int UPPER_MSB  = 19;
    localparam int MIDDLE_LSB = 8;              // middle byte: pre_en_n, main[6:0]
    localparam int MIDDLE_MSB = 15;
    localparam int LOW_LSB    = 0;              // low byte: ref[3:0], swallow[3:0]
    localparam int LOW_MSB    = 7;
    localparam int REF_HI_MSB = 19;             // ref[5:4]
    localparam int REF_HI_LSB = 18;
    localparam int MAIN_HI_MSB = 17;            // main[8:7]
    localparam int MAIN_HI_LSB = 16;
    localparam int PRE_EN_BIT = 15;             // prescaler enable, active low
    localparam int MAIN_LO_MSB = 14;            // main[6:0]
    localparam int MAIN_LO_LSB = 8;
    localparam int REF_LO_MSB = 7;              // ref[3:0]
    localparam int REF_LO_LSB = 4;
    localparam int SWAL_MSB   = 3;              // swallow[3:0]
    localparam int SWAL_LSB   = 0;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [PRIM_WIDTH-1:0] PRIM_RESET = 20'h00000;
    localparam logic [ENH_WIDTH-1:0]  ENH_RESET  = 8'h00;

    // interface mode chosen by the mode select pins
    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_SERIAL,
        MODE_PARALLEL
    } sdp_mode_t;

    // settings handed to the counters
    typedef struct packed {
        logic [5:0]           ref_count;
        logic [8:0]           main_count;
        logic [3:0]           swallow_count;
        logic                 prescale_bypass;  // high: oscillator skips prescaler
        logic [ENH_WIDTH-1:0] enh_active;       // zero while enhancement disabled
    } sdp_counts_t;

    // every pin except shift clock and shift data sampled into the system clock domain
    typedef struct packed {
        logic                 load_n;
        logic                 enh_write;
        logic                 commit;
        logic                 direct_mode;
        logic                 serial_mode;
        logic                 serial_word_select;
        logic                 parallel_word_select;
        logic                 upper_nibble_write;
        logic                 middle_byte_write;
        logic                 low_byte_write;
        logic                 enh_enable_n;
        logic [BUS_WIDTH-1:0] data;
        logic [3:0]           dir_ref;
        logic [6:0]           dir_main;
        logic [3:0]           dir_swallow;
        logic                 dir_pre_en_n;
    } sdp_pins_t;

endpackage : sdp_pkg

// *** verilog/sdp_program_port.sv ***
// Operation
// - direct mode select high: counters take settings from hardwired pins
// - otherwise serial mode select chooses serial port, low chooses parallel
// - serial shifting happens only while the load strobe is held low
// - serial word arrives most significant bit first
// - shift clock rise loads the primary shadow, or the enhancement shadow when enhancement write high
// - serial mode only: load rise copies shadows into primary, secondary and enhancement; serial or parallel mode: commit rise copies primary into secondary
// - serial mode: word select high uses primary, low uses secondary
// - parallel mode: word select high uses primary, low uses secondary
// - enhancement write rise captures all eight bus bits into enhancement
// - upper nibble write rise stores bus[3:0] into ref[5:4], main[8:7]
// - middle byte write rise stores prescaler enable and main[6:0]
// - low byte write rise stores ref[3:0] and swallow[3:0]
// - prescaler enable is active low; high bypasses the prescaler
// - direct mode: four pins set reference counter, index 0 least significant
// - direct mode: seven pins set main counter low bits
// - direct mode: four pins set swallow counter, index 3 most significant
// - parallel bus is eight bits, bit 0 least significant
// - enhancement bits act only while enhancement enable input is low
`timescale 1ns/1ps
`default_nettype none

module sdp_program_port #(
    parameter int PRIM_W = 20,
    parameter int ENH_W  = 8
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         shift_clk,
    input  wire logic                         shift_data,
    input  wire logic                         load_n,
    input  wire logic                         enh_write,
    input  wire logic                         commit_strobe,
    input  wire logic                         direct_mode,
    input  wire logic                         serial_mode,
    input  wire logic                         serial_word_select,
    input  wire logic                         parallel_word_select,
    input  wire logic [sdp_pkg::BUS_WIDTH-1:0] par_data,
    input  wire logic                         upper_nibble_write,
    input  wire logic                         middle_byte_write,
    input  wire logic                         low_byte_write,
    input  wire logic                         enh_enable_n,
    input  wire logic [3:0]                   direct_ref,
    input  wire logic [6:0]                   direct_main,
    input  wire logic [3:0]                   direct_swallow,
    input  wire logic                         direct_pre_en_n,
    output var  sdp_pkg::sdp_counts_t         counts,
    output var  sdp_pkg::sdp_mode_t           active_mode
);
    import sdp_pkg::*;

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    // the field layout is fixed, so only the documented widths are served
    if (PRIM_W != PRIM_WIDTH || ENH_W != ENH_WIDTH) begin : g_width_check
        $error("sdp_program_port: register widths must match the field layout");
    end

    // rising edge of a sampled level against its previous sample
    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : rise

    // ------------------------------------------------------------------------
    // shift clock domain
    // ------------------------------------------------------------------------
    // shift shadows; no reset exists for this domain, contents are data only
    // power-up zero keeps a load before the first full word from copying unknowns
    logic [PRIM_W-1:0] shift_prim = '0;
    logic [ENH_W-1:0]  shift_enh  = '0;
    wire               shift_on   = ~load_n;
    wire               shift_prim_en = shift_on & ~enh_write;
    wire               shift_enh_en  = shift_on & enh_write;

    always_ff @(posedge shift_clk) begin
        if (shift_prim_en) begin
            shift_prim <= {shift_prim[PRIM_W-2:0], shift_data};
        end
        if (shift_enh_en) begin
            shift_enh <= {shift_enh[ENH_W-2:0], shift_data};
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    sdp_pins_t pins_raw;
    sdp_pins_t pins_meta;
    sdp_pins_t pins_sync;
    sdp_pins_t pins_prev;

    assign pins_raw = '{
        load_n:               load_n,
        enh_write:            enh_write,
        commit:               commit_strobe,
        direct_mode:          direct_mode,
        serial_mode:          serial_mode,
        serial_word_select:   serial_word_select,
        parallel_word_select: parallel_word_select,
        upper_nibble_write:   upper_nibble_write,
        middle_byte_write:    middle_byte_write,
        low_byte_write:       low_byte_write,
        enh_enable_n:         enh_enable_n,
        data:                 par_data,
        dir_ref:              direct_ref,
        dir_main:             direct_main,
        dir_swallow:          direct_swallow,
        dir_pre_en_n:         direct_pre_en_n
    };

    // two stages, then one more only for edge detection of the strobes
    always_ff @(posedge clk_sys) begin
        pins_meta <= pins_raw;
        pins_sync <= pins_meta;
        pins_prev <= pins_sync;
    end

    // ------------------------------------------------------------------------
    // mode and strobe decode
    // ------------------------------------------------------------------------
    sdp_mode_t next_mode;

    assign next_mode = pins_sync.direct_mode ? MODE_DIRECT :
                       pins_sync.serial_mode ? MODE_SERIAL : MODE_PARALLEL;

    wire is_serial   = (next_mode == MODE_SERIAL);
    wire is_parallel = (next_mode == MODE_PARALLEL);
    // load strobe rise ends a frame; the shift shadows are quiet by then
    wire load_rise   = is_serial & rise(pins_sync.load_n, pins_prev.load_n);
    wire commit_rise = ~pins_sync.direct_mode & rise(pins_sync.commit, pins_prev.commit);
    wire enh_rise    = is_parallel & rise(pins_sync.enh_write, pins_prev.enh_write);
    wire upper_rise  = is_parallel &
                       rise(pins_sync.upper_nibble_write, pins_prev.upper_nibble_write);
    wire middle_rise = is_parallel &
                       rise(pins_sync.middle_byte_write, pins_prev.middle_byte_write);
    wire low_rise    = is_parallel & rise(pins_sync.low_byte_write, pins_prev.low_byte_write);

    // ------------------------------------------------------------------------
    // primary, secondary and enhancement registers
    // ------------------------------------------------------------------------
    logic [PRIM_W-1:0] primary_divider_word;
    logic [PRIM_W-1:0] secondary_word;
    logic [ENH_W-1:0]  enhancement_options;
    logic [PRIM_W-1:0] next_primary;
    logic [PRIM_W-1:0] next_secondary;
    logic [ENH_W-1:0]  next_enh;

    // parallel writes update separate fields, so several may land in one cycle
    always_comb begin
        next_primary = primary_divider_word;
        if (load_rise) begin
            // serial frame end makes the shifted word live
            next_primary = shift_prim;
        end
        if (upper_rise) begin
            next_primary[UPPER_MSB:UPPER_LSB] = pins_sync.data[3:0];
        end
        if (middle_rise) begin
            next_primary[MIDDLE_MSB:MIDDLE_LSB] = pins_sync.data;
        end
        if (low_rise) begin
            next_primary[LOW_MSB:LOW_LSB] = pins_sync.data;
        end
    end

    assign next_secondary = load_rise   ? shift_prim :
                            commit_rise ? primary_divider_word : secondary_word;

    assign next_enh = enh_rise  ? pins_sync.data :
                      load_rise ? shift_enh : enhancement_options;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            primary_divider_word <= PRIM_RESET;
            secondary_word       <= PRIM_RESET;
            enhancement_options  <= ENH_RESET;
        end else begin
            primary_divider_word <= next_primary;
            secondary_word       <= next_secondary;
            enhancement_options  <= next_enh;
        end
    end

    // ------------------------------------------------------------------------
    // counter settings
    // ------------------------------------------------------------------------
    logic [PRIM_W-1:0] word_sel;
    sdp_counts_t       next_counts;

    always_comb begin
        word_sel = secondary_word;
        unique case (next_mode)
            MODE_SERIAL:   word_sel = pins_sync.serial_word_select ?
                                      primary_divider_word : secondary_word;
            MODE_PARALLEL: word_sel = pins_sync.parallel_word_select ?
                                      primary_divider_word : secondary_word;
            MODE_DIRECT:   word_sel = secondary_word;
            default:       word_sel = secondary_word;
        endcase
    end

    always_comb begin
        next_counts = '0;
        if (next_mode == MODE_DIRECT) begin
            next_counts.ref_count       = {2'b00, pins_sync.dir_ref};
            next_counts.main_count      = {2'b00, pins_sync.dir_main};
            next_counts.swallow_count   = pins_sync.dir_swallow;
            next_counts.prescale_bypass = pins_sync.dir_pre_en_n;
            // enhancement is a serial and parallel feature only
            next_counts.enh_active      = '0;
        end else begin
            next_counts.ref_count       = {word_sel[REF_HI_MSB:REF_HI_LSB],
                                           word_sel[REF_LO_MSB:REF_LO_LSB]};
            next_counts.main_count      = {word_sel[MAIN_HI_MSB:MAIN_HI_LSB],
                                           word_sel[MAIN_LO_MSB:MAIN_LO_LSB]};
            next_counts.swallow_count   = word_sel[SWAL_MSB:SWAL_LSB];
            next_counts.prescale_bypass = word_sel[PRE_EN_BIT];
            next_counts.enh_active      = pins_sync.enh_enable_n ? '0 : enhancement_options;
        end
    end

    // outputs come straight from flip-flops, one cycle behind the decode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            counts      <= '0;
            active_mode <= MODE_DIRECT;
        end else begin
            counts      <= next_counts;
            active_mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    // primary shift check
    AST_SHIFT_PRIM: assert property (@(posedge shift_clk)
        (!load_n && !enh_write) |=> shift_prim == {$past(shift_prim[PRIM_W-2:0]), $past(shift_data)})
        else $error("primary shadow did not shift msb first");

    AST_SHIFT_HOLD: assert property (@(posedge shift_clk)
        load_n |=> $stable(shift_prim) && $stable(shift_enh))
        else $error("shadow changed outside a load frame");

    AST_DIRECT_SRC: assert property (@(posedge clk_sys) disable iff (rst)
        pins_sync.direct_mode |=> active_mode == MODE_DIRECT &&
        counts.swallow_count == $past(pins_sync.dir_swallow) &&
        counts.ref_count == {2'b00, $past(pins_sync.dir_ref)})
        else $error("direct mode did not follow hardwired pins");

    AST_DIRECT_MAIN: assert property (@(posedge clk_sys) disable iff (rst)
        pins_sync.direct_mode |=> counts.main_count == {2'b00, $past(pins_sync.dir_main)} &&
        counts.prescale_bypass == $past(pins_sync.dir_pre_en_n) && counts.enh_active == '0)
        else $error("direct mode main count or bypass wrong");

    AST_MODE_SEL: assert property (@(posedge clk_sys) disable iff (rst)
        (!pins_sync.direct_mode && !pins_sync.serial_mode) |=> active_mode == MODE_PARALLEL)
        else $error("parallel mode not selected");

    AST_SER_REFUSE: assert property (@(posedge clk_sys) disable iff (rst)
        (is_serial && !load_rise) |=> primary_divider_word == $past(primary_divider_word))
        else $error("primary changed in serial mode without a load");

    AST_LOAD_COPY: assert property (@(posedge clk_sys) disable iff (rst)
        load_rise |=> secondary_word == $past(shift_prim) && primary_divider_word == $past(shift_prim))
        else $error("load strobe rise did not copy the word");

    AST_COMMIT: assert property (@(posedge clk_sys) disable iff (rst)
        (commit_rise && !load_rise) |=> secondary_word == $past(primary_divider_word))
        else $error("commit strobe did not copy primary");

    AST_FSEL_SER: assert property (@(posedge clk_sys) disable iff (rst)
        (is_serial && pins_sync.serial_word_select) |=>
        counts.swallow_count == $past(primary_divider_word[SWAL_MSB:SWAL_LSB]))
        else $error("serial select did not use primary");

    AST_FSEL_PAR: assert property (@(posedge clk_sys) disable iff (rst)
        (is_parallel && !pins_sync.parallel_word_select) |=>
        counts.main_count[6:0] == $past(secondary_word[MAIN_LO_MSB:MAIN_LO_LSB]))
        else $error("parallel select did not use secondary");

    AST_BYPASS: assert property (@(posedge clk_sys) disable iff (rst)
        (is_parallel && pins_sync.parallel_word_select) |=>
        counts.prescale_bypass == $past(primary_divider_word[PRE_EN_BIT]))
        else $error("prescaler bypass does not follow the enable bit");

    AST_ENH_WR: assert property (@(posedge clk_sys) disable iff (rst)
        enh_rise |=> enhancement_options == $past(pins_sync.data))
        else $error("enhancement write lost");

    AST_UPPER: assert property (@(posedge clk_sys) disable iff (rst)
        upper_rise |=> primary_divider_word[UPPER_MSB:UPPER_LSB] == $past(pins_sync.data[3:0]))
        else $error("upper nibble write lost");

    AST_MIDDLE: assert property (@(posedge clk_sys) disable iff (rst)
        middle_rise |=> primary_divider_word[MIDDLE_MSB:MIDDLE_LSB] == $past(pins_sync.data))
        else $error("middle byte write lost");

    AST_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        (low_rise && !load_rise) |=> primary_divider_word[LOW_MSB:LOW_LSB] == $past(pins_sync.data))
        else $error("low byte write lost");

    AST_ENH_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        pins_sync.enh_enable_n |=> counts.enh_active == '0)
        else $error("enhancement bits active while disabled");

endmodule : sdp_program_port

`default_nettype wire

// *** dv/sdp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// host controller model driving the serial and parallel programming pins
// ----------------------------------------------------------------------------
module sdp_host_model (
    input  wire logic       clk_sys,
    output var  logic       shift_clk,
    output var  logic       shift_data,
    output var  logic       load_n,
    output var  logic       enh_write,
    output var  logic       commit_strobe,
    output var  logic [7:0] par_data,
    output var  logic       upper_nibble_write,
    output var  logic       middle_byte_write,
    output var  logic       low_byte_write
);
    logic [4:0] stb;
    logic       ser_enh;

    // one strobe per target; enh_write also routes serial shifts
    assign upper_nibble_write = stb[0];
    assign middle_byte_write  = stb[1];
    assign low_byte_write     = stb[2];
    assign commit_strobe      = stb[4];
    assign enh_write          = stb[3] | ser_enh;

    // idle pins at time zero, link clock standing still
    initial begin
        stb        = 5'h00;
        ser_enh    = 1'b0;
        shift_clk  = 1'b0;
        shift_data = 1'b0;
        load_n     = 1'b1;
        par_data   = 8'h00;
    end

    task automatic par_strobe(input int sel, input logic [7:0] d);
        @(posedge clk_sys) par_data <= d;
        repeat (4) @(posedge clk_sys);
        stb[sel] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        stb[sel] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        par_data <= ~d;  // released bus must not look like held data
    endtask : par_strobe

    // load low whole frame, msb first
    task automatic serial_frame(input logic [19:0] w, input logic to_enh);
        int n;
        n = to_enh ? 8 : 20;
        shift_data = ~w[n - 1];
        #24 shift_clk = 1'b1;
        #24 shift_clk = 1'b0;
        @(posedge clk_sys) ser_enh <= to_enh;
        load_n <= 1'b0;
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            shift_data = w[i];
            #24 shift_clk = 1'b1;
            #24 shift_clk = 1'b0;
        end
        shift_data = ~w[0];  // hold time over: data no longer valid
        #120;
        @(posedge clk_sys) load_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ser_enh <= 1'b0;
    endtask : serial_frame
endmodule : sdp_host_model

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// self-checking bench for the divider programming port
// ----------------------------------------------------------------------------
module tb;
    import sdp_pkg::*;
    logic        clk_sys, rst, shift_clk, shift_data, load_n, enh_write, commit_strobe;
    logic        direct_mode, serial_mode, serial_word_select, parallel_word_select;
    logic        upper_nibble_write, middle_byte_write, low_byte_write, enh_enable_n;
    logic [7:0]  par_data, enh, d;
    logic [3:0]  direct_ref, direct_swallow;
    logic [6:0]  direct_main;
    logic        direct_pre_en_n;
    logic [19:0] prim, sec, w;
    sdp_counts_t counts;
    sdp_mode_t   active_mode;
    sdp_counts_t q_cnt[$];
    sdp_mode_t   q_mode[$];
    event        result_ev;
    int          miscompares = 0;
    int          checked = 0;
    integer      seed = 72170;

    sdp_program_port sdp_program_port_i (
        .clk_sys(clk_sys), .rst(rst), .shift_clk(shift_clk), .shift_data(shift_data),
        .load_n(load_n), .enh_write(enh_write), .commit_strobe(commit_strobe),
        .direct_mode(direct_mode), .serial_mode(serial_mode),
        .serial_word_select(serial_word_select), .parallel_word_select(parallel_word_select),
        .par_data(par_data), .upper_nibble_write(upper_nibble_write),
        .middle_byte_write(middle_byte_write), .low_byte_write(low_byte_write),
        .enh_enable_n(enh_enable_n), .direct_ref(direct_ref), .direct_main(direct_main),
        .direct_swallow(direct_swallow), .direct_pre_en_n(direct_pre_en_n),
        .counts(counts), .active_mode(active_mode));

    sdp_host_model sdp_host_model_i (
        .clk_sys(clk_sys), .shift_clk(shift_clk), .shift_data(shift_data), .load_n(load_n),
        .enh_write(enh_write), .commit_strobe(commit_strobe), .par_data(par_data),
        .upper_nibble_write(upper_nibble_write), .middle_byte_write(middle_byte_write),
        .low_byte_write(low_byte_write));

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------------
    // expectation model
    // ------------------------------------------------------------------------
    function automatic sdp_counts_t model_counts();
        logic [19:0] p;
        if (direct_mode) begin
            return {2'b00, direct_ref, 2'b00, direct_main, direct_swallow, direct_pre_en_n, 8'h00};
        end
        p = (serial_mode ? serial_word_select : parallel_word_select) ? prim : sec;
        return {p[19:18], p[7:4], p[17:16], p[14:8], p[3:0], p[15], enh_enable_n ? 8'h00 : enh};
    endfunction : model_counts

    // note the expectation, then let the sync and output stages settle
    task automatic check_out();
        @(posedge clk_sys);
        q_cnt.push_back(model_counts());
        q_mode.push_back(direct_mode ? MODE_DIRECT : serial_mode ? MODE_SERIAL : MODE_PARALLEL);
        repeat (8) @(posedge clk_sys);
        ->result_ev;
    endtask : check_out

    task automatic cmp_counts(input sdp_counts_t e, input sdp_counts_t a);
        checked++;
        if (a !== e) begin
            miscompares++;
            $display("Error %0t counts expected %h got %h", $time, e, a);
        end
    endtask : cmp_counts

    task automatic cmp_mode(input sdp_mode_t e, input sdp_mode_t a);
        checked++;
        if (a !== e) begin
            miscompares++;
            $display("Error %0t mode expected %0d got %0d", $time, e, a);
        end
    endtask : cmp_mode

    // monitor: oldest note against what the outputs show now
    always @(result_ev) begin
        cmp_counts(q_cnt.pop_front(), counts);
        cmp_mode(q_mode.pop_front(), active_mode);
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // the whole run needs about 10 us; thirty times that means a hang
    initial begin
        #300_000;
        miscompares++;
        $display("Error %0t watchdog expired", $time);
        give_verdict();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        {rst, direct_mode, serial_word_select, parallel_word_select} = 4'hF;
        {serial_mode, enh_enable_n} = 2'b00;
        {direct_ref, direct_main, direct_swallow, direct_pre_en_n} = 16'h0000;
        {prim, sec, enh} = 48'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            {direct_ref, direct_main, direct_swallow, direct_pre_en_n} <= 16'($random(seed));
            check_out();
        end
        $display("test direct done");
        direct_mode <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            sdp_host_model_i.par_strobe(i, d);
            case (i)
                0: prim[19:16] = d[3:0];
                1: prim[15:8] = d;
                2: prim[7:0] = d;
                default: enh = d;
            endcase
            check_out();
        end
        parallel_word_select <= 1'b0;
        check_out();
        sdp_host_model_i.par_strobe(4, 8'h00);
        sec = prim;
        check_out();
        enh_enable_n <= 1'b1;
        check_out();
        d = 8'($random(seed));
        sdp_host_model_i.par_strobe(2, d);
        prim[7:0] = d;
        check_out();
        $display("test parallel done");
        serial_mode <= 1'b1;
        check_out();
        serial_word_select <= 1'b0;
        check_out();
        sdp_host_model_i.par_strobe(4, 8'h00);
        sec = prim;
        check_out();
        {serial_word_select, enh_enable_n} <= 2'b10;
        d = 8'($random(seed));
        sdp_host_model_i.serial_frame({12'h000, d}, 1'b1);
        enh = d;
        for (int j = 0; j < 3; j++) begin
            w = 20'($random(seed));
            sdp_host_model_i.serial_frame(w, 1'b0);
            {prim, sec} = {w, w};
            check_out();
        end
        sdp_host_model_i.par_strobe(2, 8'($random(seed)));
        check_out();
        $display("test serial done");
        give_verdict();
    end
endmodule : tb

`default_nettype wire
